/* pll_counter_lock_control.sv */
/*
 Digital control side of the phase-locked loop: divider, phase and duty
 settings, reference switchover, lock gating counter, feedback mode and
 output routing, with an AXI4-Lite register slave and interrupt.
 Assumes reference clocks and the raw analog lock arrive asynchronously;
 they are synchronised here. The analog loop itself lies outside.
*/
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
// Functional notes
// - Output frequency is ref times feedback over divisors
// - Phase steps of oscillator period over eight
// - Each post scaler has programmable duty cycle
// - Three post-scaled outputs feed global clocks
// - Third output drives pin and/or global network
// - Lock only when clock stable and in phase
// - Gated lock held low for counted transitions
// - Gated or raw lock selectable for output
// - Zero delay mode aligns pin with input
// - Normal mode compensates global network delay
// - No compensation mode applies no compensation
// - Enable input enables and disables the loop
// - Loop reset resynchronises loop inputs
// - Detector gate blocks detector updates when low
// - Differential reference consumes paired input pins
// - Switch selector static or dynamic picks reference
`timescale 1ns/10ps
module pll_counter_lock_control
   import pll_ctrl_pkg::*;
#(
   parameter int LOCK_COUNT_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic loop_enable,
   input wire logic loop_reset,
   input wire logic detector_gate_enable,
   input wire logic reference_switch_select,
   input wire logic ref_clk0,
   input wire logic ref_clk1,
   input wire logic raw_lock_in,
   output logic reference_sel,
   output logic differential_pair_used,
   output logic loop_run,
   output logic detector_update,
   output divide_type divide_out,
   output logic [11:0] phase_out,
   output logic [14:0] duty_out,
   output logic [1:0] feedback_mode,
   output logic [2:0] global_drive,
   output logic external_pin_drive,
   output logic lock_out,
   output logic irq
);
   logic [31:0] control_ff;
   logic [31:0] divide_ff;
   logic [31:0] phase_ff;
   logic [31:0] duty_ff;
   logic [LOCK_COUNT_W-1:0] lock_count_ff;
   logic [2:0] irq_status_ff;
   logic [2:0] irq_mask_ff;
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [7:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   read_answer_type rd_ff;

   // Two-flop synchronisers for asynchronous inputs
   logic [2:0] sync_a_ff;
   logic [2:0] sync_b_ff;
   logic [1:0] sync_c_ff;
   logic [1:0] sync_d_ff;
   logic ref_prev_ff;
   logic lock_prev_ff;
   logic sel_prev_ff;
   logic [LOCK_COUNT_W-1:0] edge_cnt_ff;
   logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_ff;
   logic gated_lock_ff;
   logic lock_out_ff;
   logic en_s;
   logic rst_s;
   logic pfd_s;
   logic sel_s;
   logic ref_s;
   logic lock_s;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync_a_ff <= 3'h0;
         sync_b_ff <= 3'h0;
         sync_c_ff <= 2'h0;
         sync_d_ff <= 2'h0;
      end else begin
         sync_a_ff <= {loop_enable, loop_reset, detector_gate_enable};
         sync_b_ff <= sync_a_ff;
         sync_c_ff <= {reference_switch_select, raw_lock_in};
         sync_d_ff <= sync_c_ff;
      end
   end

   assign en_s = sync_b_ff[2];
   assign rst_s = sync_b_ff[1];
   assign pfd_s = sync_b_ff[0];
   assign lock_s = sync_d_ff[0];

   // Static config or dynamic pin picks the reference
   assign sel_s = control_ff[CTL_DYN_SWITCH] ? sync_d_ff[1] : control_ff[CTL_REF_SEL];

   // Reference clock sampled as a level; a slow reference is assumed
   logic [1:0] ref0_sync_ff;
   logic [1:0] ref1_sync_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref0_sync_ff <= 2'h0;
         ref1_sync_ff <= 2'h0;
      end else begin
         ref0_sync_ff <= {ref0_sync_ff[0], ref_clk0};
         ref1_sync_ff <= {ref1_sync_ff[0], ref_clk1};
      end
   end
   assign ref_s = sel_s ? ref1_sync_ff[1] : ref0_sync_ff[1];

   // Software enable and the pin must both agree before the loop runs
   wire loop_on = en_s && !rst_s && control_ff[CTL_ENABLE];
   wire ref_edge = ref_s != ref_prev_ff;
   wire switched = sel_s != sel_prev_ff;
   wire settled = settle_ff == SETTLE_CYCLES[$bits(settle_ff)-1:0];
   wire stable_lock = lock_s && settled && loop_on;
   // Both reference edges count, so the count is in half periods
   wire count_done = edge_cnt_ff >= lock_count_ff;
   // Any doubt about the loop restarts settling and edge counting
   wire count_clear = !loop_on || switched || !lock_s;
   wire count_step = ref_edge && !count_done;
   wire nxt_gated = stable_lock && count_done;
   wire sel_lock = control_ff[CTL_LOCK_SRC] ? stable_lock : gated_lock_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_prev_ff <= 1'b0;
         sel_prev_ff <= 1'b0;
         lock_prev_ff <= 1'b0;
         edge_cnt_ff <= '0;
         settle_ff <= '0;
         gated_lock_ff <= 1'b0;
         lock_out_ff <= 1'b0;
      end else begin
         ref_prev_ff <= ref_s;
         sel_prev_ff <= sel_s;
         lock_prev_ff <= lock_out_ff;
         lock_out_ff <= sel_lock;
         gated_lock_ff <= nxt_gated;
         if (count_clear) begin
            edge_cnt_ff <= '0;
            settle_ff <= '0;
         end else begin
            if (count_step) begin
               edge_cnt_ff <= edge_cnt_ff + 1'b1;
            end
            if (!settled) begin
               settle_ff <= settle_ff + 1'b1;
            end
         end
      end
   end

   // Register field fan-out to the analog loop
   assign divide_out = divide_type'(divide_ff[21:0]);
   assign phase_out = phase_ff[11:0];
   assign duty_out = duty_ff[14:0];
   assign feedback_mode = control_ff[CTL_FB_LSB +: 2];
   assign global_drive = control_ff[CTL_GLB_LSB +: SCALERS] & {SCALERS{loop_on}};
   assign external_pin_drive = control_ff[CTL_EXT_EN] && loop_on;
   assign differential_pair_used = control_ff[CTL_DIFF];
   assign reference_sel = sel_s;
   assign loop_run = loop_on;
   assign detector_update = loop_on && pfd_s && control_ff[CTL_PFD_GATE];
   assign lock_out = lock_out_ff;

   // AXI4-Lite write path
   // Address and data may arrive in either order; each waits parked
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
   assign s_axi_wready = !w_hold_ff && !bvalid_ff;
   wire have_aw = aw_hold_ff || aw_take;
   wire have_w = w_hold_ff || w_take;
   wire do_write = have_aw && have_w && !bvalid_ff;
   wire [7:0] waddr = aw_take ? s_axi_awaddr[7:0] : awaddr_ff;
   wire [31:0] wdata = w_take ? s_axi_wdata : wdata_ff;
   wire [3:0] wstrb = w_take ? s_axi_wstrb : wstrb_ff;
   wire [31:0] wmask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= OFS_IRQ_MASK);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] m);
      merge = (old_v & ~m) | (new_v & m);
   endfunction

   wire wr_ok = do_write && mapped(waddr);
   wire [31:0] nxt_control = merge(control_ff, wdata, wmask);
   wire [31:0] nxt_lock32 = merge(32'(lock_count_ff), wdata, wmask);

   // Reserved feedback code falls back to normal mode
   wire [31:0] ctl_fixed = (nxt_control[CTL_FB_LSB +: 2] == fb_reserved) ?
      (nxt_control & ~(32'h3 << CTL_FB_LSB)) : nxt_control;

   // Zero divider values are raised to one, keeping ratios legal
   function automatic logic [31:0] fix_div(input logic [31:0] v);
      logic [31:0] r;
      r = v & 32'h003F_FFFF;
      if (r[1:0] == 2'h0) begin
         r[1:0] = 2'h1;
      end
      for (int i = 0; i < 4; i++) begin
         if (r[2 + 5*i +: 5] == 5'h00) begin
            r[2 + 5*i +: 5] = 5'h01;
         end
      end
      fix_div = r;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= 2'h0;
      end else begin
         if (do_write) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= mapped(waddr) ? 2'h0 : 2'h2;
         end else begin
            if (aw_take) begin
               aw_hold_ff <= 1'b1;
               awaddr_ff <= s_axi_awaddr[7:0];
            end
            if (w_take) begin
               w_hold_ff <= 1'b1;
               wdata_ff <= s_axi_wdata;
               wstrb_ff <= s_axi_wstrb;
            end
            if (bvalid_ff && s_axi_bready) begin
               bvalid_ff <= 1'b0;
            end
         end
      end
   end

   // One select per register keeps the write process short
   wire wr_control = wr_ok && (waddr == OFS_CONTROL);
   wire wr_divide = wr_ok && (waddr == OFS_DIVIDE);
   wire wr_phase = wr_ok && (waddr == OFS_PHASE);
   wire wr_duty = wr_ok && (waddr == OFS_DUTY);
   wire wr_lock_count = wr_ok && (waddr == OFS_LOCK_COUNT);
   wire wr_mask = wr_ok && (waddr == OFS_IRQ_MASK);
   wire [31:0] nxt_divide = fix_div(merge(divide_ff, wdata, wmask));
   wire [31:0] nxt_phase = merge(phase_ff, wdata, wmask) & 32'h0000_0FFF;
   wire [31:0] nxt_duty = merge(duty_ff, wdata, wmask) & 32'h0000_7FFF;
   wire [31:0] nxt_mask32 = merge(32'(irq_mask_ff), wdata, wmask);
   // Status words are read only: a write there answers OKAY and changes nothing

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_ff <= RST_CONTROL;
         divide_ff <= fix_div(RST_DIVIDE);
         phase_ff <= RST_PHASE;
         duty_ff <= RST_DUTY;
         lock_count_ff <= LOCK_COUNT_W'(RST_LOCK_COUNT);
         irq_mask_ff <= RST_IRQ_MASK;
      end else begin
         if (wr_control) begin
            control_ff <= ctl_fixed & 32'h0000_0FFF;
         end
         if (wr_divide) begin
            divide_ff <= nxt_divide;
         end
         if (wr_phase) begin
            phase_ff <= nxt_phase;
         end
         if (wr_duty) begin
            duty_ff <= nxt_duty;
         end
         if (wr_lock_count) begin
            lock_count_ff <= nxt_lock32[LOCK_COUNT_W-1:0];
         end
         if (wr_mask) begin
            irq_mask_ff <= nxt_mask32[2:0];
         end
      end
   end

   // AXI4-Lite read path
   wire ar_take = s_axi_arvalid && s_axi_arready;
   // Only one read in flight, so arready just waits on the answer
   assign s_axi_arready = !rvalid_ff;
   wire [7:0] raddr = s_axi_araddr[7:0];
   // Status bits in the order software sees them
   wire [4:0] status_bits = {gated_lock_ff, stable_lock, sel_s, loop_on, lock_s};
   wire [31:0] status_word = {27'h0, status_bits};
   wire [31:0] rmux =
      (raddr == OFS_CONTROL) ? control_ff :
      (raddr == OFS_DIVIDE) ? divide_ff :
      (raddr == OFS_PHASE) ? phase_ff :
      (raddr == OFS_DUTY) ? duty_ff :
      (raddr == OFS_LOCK_COUNT) ? 32'(lock_count_ff) :
      (raddr == OFS_STATUS) ? status_word :
      (raddr == OFS_IRQ_STATUS) ? {29'h0, irq_status_ff} :
      (raddr == OFS_IRQ_MASK) ? {29'h0, irq_mask_ff} : 32'h0000_0000;
   wire irq_rd = ar_take && (raddr == OFS_IRQ_STATUS);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
         rd_ff <= '0;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rd_ff.data <= rmux;
         rd_ff.resp <= mapped(raddr) ? 2'h0 : 2'h2;
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // Events: lock gained, lock lost, reference switched; set beats read clear
   wire lock_rise = !lock_prev_ff && lock_out_ff;
   wire lock_fall = lock_prev_ff && !lock_out_ff;
   wire [2:0] events = {switched, lock_fall, lock_rise};
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_ff <= 3'h0;
      end else begin
         irq_status_ff <= (irq_rd ? 3'h0 : irq_status_ff) | events;
      end
   end

   // Level output; software clears it by reading the event word
   assign irq = |(irq_status_ff & irq_mask_ff);
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata = rd_ff.data;
   assign s_axi_rresp = rd_ff.resp;
endmodule // pll_counter_lock_control

/* pll_counter_lock_control_tb_top.sv */
/* Bench for pll_counter_lock_control: registers, lock, interrupt.
   Assumes the reference source model and the bound checker. */
`timescale 1ns/10ps
module pll_counter_lock_control_tb_top
   import pll_ctrl_pkg::*;
;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic [1:0] rs;} row_type;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0;
   logic loop_enable = '0, loop_reset = '0, detector_gate_enable = 1'h1;
   logic reference_switch_select = '0, ref_clk0, ref_clk1, raw_lock_in;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, feedback_mode;
   logic reference_sel, differential_pair_used, loop_run, detector_update;
   divide_type divide_out;
   logic [11:0] phase_out;
   logic [14:0] duty_out;
   logic [2:0] global_drive;
   logic external_pin_drive, lock_out, irq;
   int err_total = 0;
   int check_count = 0;
   row_type rows [8] = '{'{OFS_CONTROL, '1, 32'hFCF, 2'h0},
      '{OFS_DIVIDE, 32'h003E_20D3, 32'h003E_20D3, 2'h0}, '{OFS_PHASE, '1, 32'hFFF, 2'h0},
      '{OFS_DUTY, '1, 32'h7FFF, 2'h0}, '{OFS_LOCK_COUNT, 32'hFFFF_0004, 32'h4, 2'h0},
      '{OFS_IRQ_MASK, '1, 32'h7, 2'h0}, '{8'h20, '1, '0, 2'h2}, '{8'h06, '1, '0, 2'h2}};
   pll_counter_lock_control i_dut (.*);
   pll_ref_source i_src (.loop_run, .ref_clk0, .ref_clk1, .raw_lock_in);
   always #12.5 aclk = ~aclk;
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= '0;
         if (s_axi_wready) s_axi_wvalid <= '0;
      end while (!s_axi_bvalid);
      s_axi_bready <= '0;
      chk("bresp", 32'(s_axi_bresp), 32'(rs));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= '0;
      end while (!s_axi_rvalid);
      s_axi_rready <= '0;
      chk("rresp", 32'(s_axi_rresp), 32'(rs));
      chk("rdata", s_axi_rdata, exp);
   endtask
   task automatic wait_lock();
      int n;
      n = 0;
      while (lock_out !== 1'h1 && n < 600) begin
         @(posedge aclk);
         n++;
      end
      chk("lock", 32'(lock_out), 32'h1);
      chk("settle", 32'(n >= SETTLE_CYCLES), 32'h1);
   endtask
   task automatic summarize();
      if (err_total == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #(25 * 30000);
      err_total++;
      summarize();
   end
   initial begin
      cyc(20);
      aresetn <= 1'h1;
      rd(OFS_CONTROL, 32'h702, '0);
      rd(OFS_LOCK_COUNT, 32'h10, '0);
      rd(OFS_IRQ_MASK, '0, '0);
      chk("divide", 32'(divide_out), 32'h0002_1085);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d, rows[i].rs);
         rd(rows[i].a, rows[i].rd, rows[i].rs);
      end
      chk("divide", 32'(divide_out), 32'h003E_20D3);
      chk("phase", 32'(phase_out), 32'hFFF);
      chk("duty", 32'(duty_out), 32'h7FFF);
      chk("pair", 32'(differential_pair_used), 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CONTROL, 32'(i) << 4, '0);
         chk("fb", 32'(feedback_mode), (i == 3) ? '0 : 32'(i));
      end
      wr(OFS_CONTROL, 32'h4, '0);
      chk("ref", 32'(reference_sel), 32'h1);
      wr(OFS_CONTROL, 32'hC, '0);
      chk("ref", 32'(reference_sel), '0);
      reference_switch_select <= 1'h1;
      cyc(5);
      chk("ref", 32'(reference_sel), 32'h1);
      chk("irq", 32'(irq), 32'h1);
      rd(OFS_IRQ_STATUS, 32'h4, '0);
      cyc(1);
      chk("irq", 32'(irq), '0);
      wr(OFS_CONTROL, 32'h783, '0);
      loop_enable <= 1'h1;
      wait_lock();
      chk("drive", 32'({loop_run, detector_update, external_pin_drive, global_drive}), 32'h3F);
      rd(OFS_STATUS, 32'h1B, '0);
      rd(OFS_IRQ_STATUS, 32'h5, '0);
      wr(OFS_IRQ_MASK, '0, '0);
      detector_gate_enable <= '0;
      cyc(5);
      chk("detector", 32'(detector_update), '0);
      loop_enable <= '0;
      cyc(8);
      chk("off", 32'({lock_out, loop_run, external_pin_drive, global_drive}), '0);
      chk("irq", 32'(irq), '0);
      wr(OFS_IRQ_MASK, 32'h7, '0);
      chk("irq", 32'(irq), 32'h1);
      rd(OFS_IRQ_STATUS, 32'h2, '0);
      // Huge count keeps the gated path shut, so only the raw path can lock
      wr(OFS_LOCK_COUNT, 32'hFFFF, '0);
      wr(OFS_CONTROL, 32'h7C3, '0);
      detector_gate_enable <= 1'h1;
      loop_enable <= 1'h1;
      wait_lock();
      rd(OFS_STATUS, 32'hB, '0);
      loop_reset <= 1'h1;
      cyc(8);
      chk("reset", 32'({lock_out, loop_run}), '0);
      loop_reset <= '0;
      aresetn <= '0;
      cyc(2);
      aresetn <= 1'h1;
      rd(OFS_CONTROL, 32'h702, '0);
      summarize();
   end
endmodule // pll_counter_lock_control_tb_top

/* pll_ctrl_assertions.sv */
/* Port checker for pll_counter_lock_control.
   Assumes aclk and synchronous active-low aresetn; bound to the top. */
`timescale 1ns/10ps
module pll_ctrl_assertions
   import pll_ctrl_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awready,
   input wire logic s_axi_arready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic loop_run,
   input wire logic detector_update,
   input wire divide_type divide_out,
   input wire logic [1:0] feedback_mode,
   input wire logic [2:0] global_drive,
   input wire logic external_pin_drive,
   input wire logic lock_out
);
   logic [7:0] run_cnt_ff;
   // Saturates so a long run never wraps into a false short count
   always_ff @(posedge aclk) begin
      if (!aresetn || !loop_run)
         run_cnt_ff <= 8'h00;
      else if (run_cnt_ff != 8'hFF)
         run_cnt_ff <= run_cnt_ff + 8'h01;
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response changed early");
   aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while response pending");
   ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
   drive_gate_a: assert property (!loop_run |-> global_drive == 3'h0 && !external_pin_drive)
      else $error("clock drive while loop off");
   detector_gate_a: assert property (detector_update |-> loop_run)
      else $error("detector update while loop off");
   lock_drop_a: assert property (!loop_run [*3] |-> !lock_out)
      else $error("lock held while loop off");
   lock_settle_a: assert property ($rose(lock_out) |->
      $past(run_cnt_ff) >= 8'(SETTLE_CYCLES)) else $error("lock before settling");
   fb_legal_a: assert property (feedback_mode != 2'h3)
      else $error("reserved feedback mode");
   divide_ones_a: assert property (divide_out.pre != 2'h0 && divide_out.feedback != 5'h00 &&
      divide_out.first_post_scaler != 5'h00 && divide_out.second_post_scaler != 5'h00 &&
      divide_out.third_post_scaler != 5'h00) else $error("zero divider");
   reset_quiet_a: assert property (disable iff (1'h0) !aresetn |=>
      !lock_out && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs live in reset");
endmodule // pll_ctrl_assertions
bind pll_counter_lock_control pll_ctrl_assertions i_chk (.aclk, .aresetn, .s_axi_awready,
   .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .loop_run, .detector_update, .divide_out, .feedback_mode, .global_drive,
   .external_pin_drive, .lock_out);

/* pll_ctrl_pkg.sv */
/*
 Package for the loop counter and lock control block: register map,
 field layouts, reset values, lock counter timing and carrier structs.
 Assumes a 32-bit AXI4-Lite register bus clocked by aclk.
*/
package pll_ctrl_pkg;
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_DIVIDE = 8'h04;
   localparam logic [7:0] OFS_PHASE = 8'h08;
   localparam logic [7:0] OFS_DUTY = 8'h0C;
   localparam logic [7:0] OFS_LOCK_COUNT = 8'h10;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

   // Control register bit positions
   localparam int CTL_ENABLE = 0;
   localparam int CTL_PFD_GATE = 1;
   localparam int CTL_REF_SEL = 2;
   localparam int CTL_DYN_SWITCH = 3;
   localparam int CTL_FB_LSB = 4;
   localparam int CTL_LOCK_SRC = 6;
   localparam int CTL_EXT_EN = 7;
   localparam int CTL_GLB_LSB = 8;
   localparam int CTL_DIFF = 11;

   localparam logic [31:0] RST_CONTROL = 32'h0000_0702;
   localparam logic [31:0] RST_DIVIDE = 32'h0000_0000;
   localparam logic [31:0] RST_PHASE = 32'h0000_0000;
   localparam logic [31:0] RST_DUTY = 32'h0000_0000;
   localparam logic [15:0] RST_LOCK_COUNT = 16'h0010;
   localparam logic [2:0] RST_IRQ_MASK = 3'h0;

   // Status event bits
   localparam int EVT_LOCK_RISE = 0;
   localparam int EVT_LOCK_FALL = 1;
   localparam int EVT_SWITCH = 2;

   // Phase detector settling after the loop is enabled
   localparam int SETTLE_NS = 1000;
   localparam int CLK_NS = 25;
   localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

   localparam int SCALERS = 3;
   localparam int PHASE_STEPS = 8;

   typedef enum logic [1:0] {
      fb_normal,
      fb_zero_delay,
      fb_no_comp,
      fb_reserved
   } feedback_mode_type;

   typedef struct packed {
      logic [4:0] third_post_scaler;
      logic [4:0] second_post_scaler;
      logic [4:0] first_post_scaler;
      logic [4:0] feedback;
      logic [1:0] pre;
   } divide_type;

   typedef struct packed {
      logic [31:0] data;
      logic [1:0] resp;
   } read_answer_type;
endpackage

/* pll_ref_source.sv */
/* Reference clock pair and analog lock model.
   Assumes loop_run comes from the block under test. */
`timescale 1ns/10ps
module pll_ref_source #(
   parameter int HALF0_NS = 200,
   parameter int HALF1_NS = 275,
   parameter int LOCK_NS = 500
) (
   input wire logic loop_run,
   output logic ref_clk0,
   output logic ref_clk1,
   output logic raw_lock_in
);
   // Oscillators run free, well below the sampling rate
   initial begin
      ref_clk0 = 1'h0;
      forever #(HALF0_NS) ref_clk0 = ~ref_clk0;
   end
   initial begin
      ref_clk1 = 1'h0;
      forever #(HALF1_NS) ref_clk1 = ~ref_clk1;
   end
   // Loop needs time to lock; lock also lingers after stop
   initial begin
      raw_lock_in = 1'h0;
      forever @(loop_run) raw_lock_in <= #(LOCK_NS) loop_run;
   end
endmodule // pll_ref_source
